// file: sseq_status.v
// status reporting and error queue top
`timescale 1ns/1ns
`include "sseq_defs.vh"
module sseq_status #(
    parameter QW = 16,
    parameter DEPTH = `SSEQ_ERR_DEPTH
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RESET,
    // questionable condition inputs and other summary sources
    input wire [QW-1:0] QUES_COND,
    input wire OPER_SUMMARY,
    input wire SRQ_PENDING,
    input wire STD_EVENT_SUMMARY,
    input wire MSG_AVAILABLE,
    // command strobes
    input wire CMD_PRESET,
    input wire CMD_CLEAR_STATUS,
    input wire CMD_ENABLE_WRITE,
    input wire [QW-1:0] ENABLE_DATA,
    input wire QRY_CONDITION,
    input wire QRY_ENABLE,
    input wire QRY_EVENT,
    input wire QRY_STATUS_BYTE,
    input wire QRY_ERROR,
    input wire QRY_VERSION,
    // error reporting
    input wire ERR_PUSH,
    input wire [15:0] ERR_CODE,
    input wire [7:0] ERR_MSG,
    // answer
    output wire RESP_VALID,
    output wire [QW-1:0] RESP_DATA,
    output wire [15:0] RESP_ERR_CODE,
    output wire [7:0] RESP_ERR_MSG,
    output wire [15:0] RESP_VER_YEAR,
    output wire [3:0] RESP_VER_REV,
    // live summary
    output wire [7:0] STATUS_BYTE
);
    // condition history and latched questionable events
    reg [QW-1:0] cond_prev_q;
    reg [QW-1:0] event_q;
    wire [QW-1:0] event_d;
    wire [QW-1:0] rise;
    wire event_clear;
    // questionable enable mask
    reg [QW-1:0] enable_q;
    reg [QW-1:0] enable_d;
    // summary byte, built from next state so it moves with the registers
    reg [7:0] status_q;
    reg [7:0] status_d;
    wire ques_sum_d;
    // answer registers
    reg resp_valid_q;
    wire resp_valid_d;
    reg [QW-1:0] resp_data_q;
    reg [QW-1:0] resp_data_d;
    reg [15:0] err_code_q;
    reg [15:0] err_code_d;
    reg [7:0] err_msg_q;
    reg [7:0] err_msg_d;
    reg [15:0] ver_year_q;
    reg [15:0] ver_year_d;
    reg [3:0] ver_rev_q;
    reg [3:0] ver_rev_d;
    // error queue head
    wire [15:0] head_code;
    wire [7:0] head_msg;
    wire q_empty;
    genvar g;

    assign event_clear = QRY_EVENT | CMD_CLEAR_STATUS;
    assign resp_valid_d = QRY_CONDITION | QRY_ENABLE | QRY_EVENT | QRY_STATUS_BYTE | QRY_ERROR | QRY_VERSION;

    // per-bit event latch; a rise in the clearing cycle survives
    generate
        for (g = 0; g < QW; g = g + 1) begin : g_event
            assign rise[g] = QUES_COND[g] & ~cond_prev_q[g];
            assign event_d[g] = event_clear ? rise[g] : (event_q[g] | rise[g]);
        end
    endgenerate

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            cond_prev_q <= {QW{1'b0}};
        end else begin
            cond_prev_q <= QUES_COND;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            event_q <= {QW{1'b0}};
        end else begin
            event_q <= event_d;
        end
    end

    // preset wins over a mask write in the same cycle
    always @* begin
        enable_d = enable_q;
        if (CMD_PRESET) begin
            enable_d = {QW{1'b0}};
        end else if (CMD_ENABLE_WRITE) begin
            enable_d = ENABLE_DATA;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            enable_q <= {QW{1'b0}};
        end else begin
            enable_q <= enable_d;
        end
    end

    assign ques_sum_d = |(event_d & enable_d);

    always @* begin
        status_d = 8'h00;
        status_d[`SSEQ_BIT_OPER] = OPER_SUMMARY;
        status_d[`SSEQ_BIT_RQS] = SRQ_PENDING;
        status_d[`SSEQ_BIT_ESB] = STD_EVENT_SUMMARY;
        status_d[`SSEQ_BIT_MAV] = MSG_AVAILABLE;
        status_d[`SSEQ_BIT_QUES] = ques_sum_d;
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            status_q <= `SSEQ_STATUS_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    sseq_err_queue #(
        .DEPTH(DEPTH),
        .AW(5)
    ) u_queue (
        .clk(CLK_SYS),
        .rst(RESET),
        .clear(CMD_CLEAR_STATUS),
        .push(ERR_PUSH),
        .push_code(ERR_CODE),
        .push_msg(ERR_MSG),
        .pop(QRY_ERROR),
        .head_code(head_code),
        .head_msg(head_msg),
        .empty(q_empty)
    );

    // query answers; condition beats enable beats event beats status byte
    always @* begin
        resp_data_d = resp_data_q;
        if (QRY_CONDITION) begin
            resp_data_d = QUES_COND;
        end else if (QRY_ENABLE) begin
            resp_data_d = enable_q;
        end else if (QRY_EVENT) begin
            resp_data_d = event_q;
        end else if (QRY_STATUS_BYTE) begin
            resp_data_d = {{(QW-8){1'b0}}, status_q};
        end
    end

    always @* begin
        err_code_d = err_code_q;
        err_msg_d = err_msg_q;
        if (QRY_ERROR && q_empty) begin
            err_code_d = `SSEQ_ERR_NONE;
            err_msg_d = `SSEQ_MSG_NONE;
        end else if (QRY_ERROR) begin
            err_code_d = head_code;
            err_msg_d = head_msg;
        end
    end

    always @* begin
        ver_year_d = ver_year_q;
        ver_rev_d = ver_rev_q;
        if (QRY_VERSION) begin
            ver_year_d = `SSEQ_VER_YEAR;
            ver_rev_d = `SSEQ_VER_REV;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            resp_valid_q <= 1'b0;
            resp_data_q <= {QW{1'b0}};
        end else begin
            resp_valid_q <= resp_valid_d;
            resp_data_q <= resp_data_d;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            err_code_q <= `SSEQ_ERR_NONE;
            err_msg_q <= `SSEQ_MSG_NONE;
        end else begin
            err_code_q <= err_code_d;
            err_msg_q <= err_msg_d;
        end
    end

    always @(posedge CLK_SYS) begin
        if (RESET) begin
            ver_year_q <= `SSEQ_VER_YEAR_RESET;
            ver_rev_q <= `SSEQ_VER_REV_RESET;
        end else begin
            ver_year_q <= ver_year_d;
            ver_rev_q <= ver_rev_d;
        end
    end

    assign RESP_VALID = resp_valid_q;
    assign RESP_DATA = resp_data_q;
    assign RESP_ERR_CODE = err_code_q;
    assign RESP_ERR_MSG = err_msg_q;
    assign RESP_VER_YEAR = ver_year_q;
    assign RESP_VER_REV = ver_rev_q;
    assign STATUS_BYTE = status_q;
endmodule

// file: sseq_defs.vh
// constants for the status and error queue block
// Summary of operation
// - status byte bits: 7 operation, 6 service request, 5 std event, 4 message, 3 questionable.
// - preset clears whole questionable enable mask, and with it status byte bit 3; std event untouched.
// - preset leaves latched event bits alone.
// - condition query returns live questionable condition bits, binary weighted.
// - enabled, set event bits drive status byte bit 3 true.
// - event bits with enable zero never touch the summary flag.
// - enable query returns the current enable mask.
// - event query returns event bits, then clears all but those rising in the same cycle.
// - each detected error pushes its code and message index into the queue.
// - error query returns and removes the oldest entry, first-in first-out.
// - empty queue answers code +0, no error.
// - clear-status empties the error queue at once.
// - queue holds 20; overflow writes -350 into newest slot, drops further errors.
// - version query returns a four-digit year and a revision number.
`ifndef SSEQ_DEFS_VH
`define SSEQ_DEFS_VH
`define SSEQ_BIT_OPER 7
`define SSEQ_BIT_RQS 6
`define SSEQ_BIT_ESB 5
`define SSEQ_BIT_MAV 4
`define SSEQ_BIT_QUES 3
`define SSEQ_ERR_DEPTH 20
`define SSEQ_ERR_NONE 16'sh0000
`define SSEQ_ERR_OVERFLOW -16'sh015E
`define SSEQ_MSG_NONE 8'h00
`define SSEQ_MSG_OVERFLOW 8'hFF
`define SSEQ_QSTAT_RESET 16'h0000
`define SSEQ_VER_YEAR 16'h07CF
`define SSEQ_VER_REV 4'h0
`define SSEQ_STATUS_RESET 8'h00
`define SSEQ_VER_YEAR_RESET 16'h0000
`define SSEQ_VER_REV_RESET 4'h0
`endif

// file: sseq_err_queue.v
// error queue: fifo of code and message index with overflow marker
`timescale 1ns/1ns
`include "sseq_defs.vh"
module sseq_err_queue #(
    parameter DEPTH = `SSEQ_ERR_DEPTH,
    parameter AW = 5
) (
    input wire clk,
    input wire rst,
    input wire clear,
    input wire push,
    input wire [15:0] push_code,
    input wire [7:0] push_msg,
    input wire pop,
    output reg [15:0] head_code,
    output reg [7:0] head_msg,
    output wire empty
);
    reg [15:0] code_mem [0:DEPTH-1];
    reg [7:0] msg_mem [0:DEPTH-1];
    reg [AW-1:0] rd_q;
    reg [AW-1:0] wr_q;
    reg [AW:0] cnt_q;
    wire full = (cnt_q == DEPTH[AW:0]);
    wire do_pop = pop && !empty;
    wire do_push = push && !full;
    wire [AW-1:0] last_slot = (wr_q == {AW{1'b0}}) ? DEPTH[AW-1:0] - 1'b1 : wr_q - 1'b1;
    assign empty = (cnt_q == {(AW+1){1'b0}});

    always @* begin
        if (empty) begin
            head_code = `SSEQ_ERR_NONE;
            head_msg = `SSEQ_MSG_NONE;
        end else begin
            head_code = code_mem[rd_q];
            head_msg = msg_mem[rd_q];
        end
    end

    always @(posedge clk) begin
        if (rst || clear) begin
            rd_q <= {AW{1'b0}};
            wr_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                code_mem[wr_q] <= push_code;
                msg_mem[wr_q] <= push_msg;
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end else if (push && full) begin
                // overflow: newest entry becomes the marker, the new error is lost
                code_mem[last_slot] <= `SSEQ_ERR_OVERFLOW;
                msg_mem[last_slot] <= `SSEQ_MSG_OVERFLOW;
            end
            if (do_pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// file: sseq_chk.sv
// port assertions for the status and error queue block
`timescale 1ns/1ns
`include "sseq_defs.vh"
module sseq_chk #(
    parameter QW = 16
) (
    // clock and reset
    input wire CLK_SYS,
    input wire RESET,
    // command and query strobes
    input wire CMD_PRESET,
    input wire CMD_CLEAR_STATUS,
    input wire CMD_ENABLE_WRITE,
    input wire ERR_PUSH,
    input wire QRY_CONDITION,
    input wire QRY_ENABLE,
    input wire QRY_EVENT,
    input wire QRY_STATUS_BYTE,
    input wire QRY_ERROR,
    input wire QRY_VERSION,
    // data and answers
    input wire [QW-1:0] QUES_COND,
    input wire [QW-1:0] ENABLE_DATA,
    input wire [QW-1:0] RESP_DATA,
    input wire RESP_VALID,
    input wire [15:0] RESP_ERR_CODE,
    input wire [15:0] RESP_VER_YEAR,
    input wire [7:0] STATUS_BYTE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sequence ev_rd; QRY_EVENT && !QRY_CONDITION && !QRY_ENABLE && $stable(QUES_COND); endsequence
    sequence en_rd; !CMD_ENABLE_WRITE ##1 QRY_ENABLE && !QRY_CONDITION; endsequence
    a_error_answer: assert property (QRY_ERROR |=> RESP_VALID) else $error("no answer");
    a_cond_value: assert property (QRY_CONDITION |=> RESP_DATA == $past(QUES_COND)) else $error("bad cond");
    a_status_low: assert property (STATUS_BYTE[2:0] == 3'h0) else $error("bad status");
    a_preset_mask: assert property (CMD_PRESET ##1 en_rd |=> RESP_DATA == 0) else $error("mask kept");
    a_mask_read: assert property (CMD_ENABLE_WRITE && !CMD_PRESET ##1 en_rd |=> RESP_DATA == $past(ENABLE_DATA, 3))
        else $error("bad mask");
    a_preset_summary: assert property (CMD_PRESET |=> !STATUS_BYTE[`SSEQ_BIT_QUES]) else $error("summary set");
    a_event_clear: assert property (ev_rd ##1 ev_rd |=> RESP_DATA == 0) else $error("event kept");
    a_empty_code: assert property (CMD_CLEAR_STATUS ##1 !ERR_PUSH ##1 QRY_ERROR && !ERR_PUSH |=> RESP_ERR_CODE == 0)
        else $error("queue kept");
    a_version_year: assert property (QRY_VERSION |=> RESP_VER_YEAR == `SSEQ_VER_YEAR) else $error("bad year");
    a_valid_quiet: assert property (!(QRY_CONDITION || QRY_ENABLE || QRY_EVENT || QRY_STATUS_BYTE
        || QRY_ERROR || QRY_VERSION) |=> !RESP_VALID) else $error("stray answer");
endmodule
bind sseq_status sseq_chk #(.QW(QW)) u_sseq_chk (.*);

// file: sseq_host.sv
// host model: holds a strobe set for n cycles, payload stepping per cycle
`timescale 1ns/1ns
module sseq_host (
    input wire clk,
    output reg [9:0] stb,
    output reg [15:0] dat,
    output reg [7:0] msg
);
    initial begin
        stb = 10'h000;
        dat = 16'h0000;
        msg = 8'h00;
    end
    task send(input [9:0] s, input [15:0] d, input integer n);
        @(posedge clk);
        #1 stb = s;
        dat = d;
        msg = d[7:0];
        repeat (n) begin
            @(posedge clk);
            #1 dat = dat + 16'h0001;
            msg = dat[7:0];
        end
        stb = 10'h000;
    endtask
endmodule

// file: status_and_error_queue_test.sv
// self-checking bench for the status and error queue block
`timescale 1ns/1ns
`include "sseq_defs.vh"
module status_and_error_queue_test;
    reg clk_sys = 0;
    reg reset = 1;
    reg [15:0] ques_cond = 16'h0000;
    reg [3:0] lv = 4'h0;
    wire [9:0] stb;
    wire [15:0] dat, resp_data, resp_err_code, resp_ver_year;
    wire [7:0] msg, resp_err_msg, status_byte;
    wire resp_valid;
    wire [3:0] resp_ver_rev;
    integer err_total = 0, total_checks = 0, i;
    initial forever #4 clk_sys = ~clk_sys;
    sseq_host u_host (.clk(clk_sys), .stb(stb), .dat(dat), .msg(msg));
    sseq_status u_sseq_status (.CLK_SYS(clk_sys), .RESET(reset), .QUES_COND(ques_cond),
        .OPER_SUMMARY(lv[3]), .SRQ_PENDING(lv[2]), .STD_EVENT_SUMMARY(lv[1]), .MSG_AVAILABLE(lv[0]),
        .CMD_PRESET(stb[0]), .CMD_CLEAR_STATUS(stb[1]), .CMD_ENABLE_WRITE(stb[2]), .ENABLE_DATA(dat),
        .QRY_CONDITION(stb[3]), .QRY_ENABLE(stb[4]), .QRY_EVENT(stb[5]), .QRY_STATUS_BYTE(stb[6]),
        .QRY_ERROR(stb[7]), .QRY_VERSION(stb[8]), .ERR_PUSH(stb[9]), .ERR_CODE(dat), .ERR_MSG(msg),
        .RESP_VALID(resp_valid), .RESP_DATA(resp_data), .RESP_ERR_CODE(resp_err_code),
        .RESP_ERR_MSG(resp_err_msg), .RESP_VER_YEAR(resp_ver_year), .RESP_VER_REV(resp_ver_rev),
        .STATUS_BYTE(status_byte));
    task chk(input [15:0] seen, input [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task er(input [15:0] c, input [7:0] m);
        u_host.send(10'h080, 16'h0000, 1);
        chk({15'h0000, resp_valid}, 16'h0001);
        chk(resp_err_code, c);
        chk({8'h00, resp_err_msg}, {8'h00, m});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total = err_total + 1;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 reset = 0;
        lv = 4'hA;
        ques_cond = 16'h0005;
        u_host.send(10'h008, 16'h0000, 1);
        chk(resp_data, 16'h0005);
        u_host.send(10'h004, 16'h0004, 1);
        chk({15'h0000, status_byte[3]}, 16'h0001);
        u_host.send(10'h010, 16'h0000, 1);
        chk(resp_data, 16'h0004);
        u_host.send(10'h004, 16'h0008, 1);
        u_host.send(10'h040, 16'h0000, 1);
        chk(resp_data, 16'h00A0);
        u_host.send(10'h001, 16'h0000, 1);
        u_host.send(10'h010, 16'h0000, 1);
        chk(resp_data, 16'h0000);
        u_host.send(10'h020, 16'h0000, 1);
        chk(resp_data, 16'h0005);
        u_host.send(10'h020, 16'h0000, 2);
        chk(resp_data, 16'h0000);
        $display("test status registers done");
        u_host.send(10'h200, 16'h0010, 3);
        for (i = 0; i < 3; i = i + 1) er(16'h0010 + i[15:0], 8'h10 + i[7:0]);
        er(16'h0000, 8'h00);
        u_host.send(10'h200, 16'h0100, 25);
        for (i = 0; i < 19; i = i + 1) er(16'h0100 + i[15:0], i[7:0]);
        er(16'hFEA2, 8'hFF);
        er(16'h0000, 8'h00);
        u_host.send(10'h200, 16'h0200, 20);
        for (i = 0; i < 20; i = i + 1) er(16'h0200 + i[15:0], i[7:0]);
        er(16'h0000, 8'h00);
        $display("test error queue done");
        ques_cond = 16'h0017;
        u_host.send(10'h020, 16'h0000, 1);
        chk(resp_data, 16'h0012);
        ques_cond = 16'h0037;
        u_host.send(10'h200, 16'h0020, 2);
        u_host.send(10'h002, 16'h0000, 1);
        er(16'h0000, 8'h00);
        u_host.send(10'h020, 16'h0000, 1);
        chk(resp_data, 16'h0000);
        u_host.send(10'h100, 16'h0000, 1);
        chk(resp_ver_year, `SSEQ_VER_YEAR);
        chk({12'h000, resp_ver_rev}, {12'h000, `SSEQ_VER_REV});
        $display("test clear and version done");
        test_done;
    end
endmodule
